// >>> rtl/sar_params.svh
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH

// Result width and number of codes
`define SAR_CODE_W 8
`define SAR_CODES 256
// Analog input word: fraction of the span 2*Vref, in 1/4096 steps
`define SAR_AIN_W 12
// Half an output step in input units, gives the +0.5 rounding
`define SAR_ROUND 13'h0008
// Input units per output step (log2)
`define SAR_STEP_SH 4
// Falling input clock edge on which the sample is frozen
`define SAR_HOLD_EDGE 5'h03
// Input clock cycles per conversion
`define SAR_CONV_EDGES 5'h14
// Internal clock ticks per conversion
`define SAR_INT_TICKS 4'ha
// First internal tick that decides a result bit
`define SAR_FIRST_BIT_TICK 4'h3
// Reset values
`define SAR_RESULT_RST 8'h00
`define SAR_SAMPLE_RST 12'h000

`endif

// >>> rtl/sar_pkg.sv
`include "sar_params.svh"

package sar_pkg;

   typedef enum logic {SAR_IDLE, SAR_CONV} sar_state_t;

   typedef struct packed {
      sar_state_t state;
      logic sel_prev;
      logic busy_n;
      logic guard;
      logic [4:0] fe_cnt;
      logic [3:0] tick_cnt;
      logic [`SAR_CODE_W-1:0] sar;
      logic [`SAR_AIN_W-1:0] sample;
      logic [`SAR_CODE_W-1:0] result;
   } sar_ctrl_t;

   typedef struct packed {
      logic clk_prev;
      logic phase;
   } sar_div_t;

endpackage

// >>> rtl/sar_clkdiv.sv
`timescale 1ns/1ps

module sar_clkdiv
   import sar_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Converter clock pin and run control
   input wire logic conv_clk_in,
   input wire logic run_in,
   // Edge and internal clock enables
   output logic fall_out,
   output logic tick_out
);

   sar_div_t s_reg;
   sar_div_t s_next;

   assign fall_out = s_reg.clk_prev & ~conv_clk_in;
   // Every second falling edge while running; stopped otherwise
   assign tick_out = fall_out & s_reg.phase & run_in; // RQ17 RQ18

   always_comb
   begin
      s_next = s_reg;
      s_next.clk_prev = conv_clk_in;
      if (!run_in)
      begin
         s_next.phase = 1'b0;
      end
      else if (fall_out)
      begin
         s_next.phase = ~s_reg.phase; // RQ17
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   a_div_by_two: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ17
      (fall_out && run_in) |=> (s_reg.phase != $past(s_reg.phase)))
      else $error("internal clock phase did not toggle on falling edge");

endmodule // sar_clkdiv

// >>> rtl/sar_adc_ctrl.sv
`timescale 1ns/1ps
`include "sar_params.svh"

//
// Overview of operation
// RQ1: Low chip select and read start conversions.
// RQ2: Resolve 256 codes, bit 0 least significant.
// RQ3: Code is floor(256*vin/(2*vref) + 0.5).
// RQ4: Busy goes low once conversion starts.
// RQ5: Track input, freeze on third falling edge.
// RQ6: Busy rises at completion; host then reads.
// RQ7: Slow-memory host waits at least 5 us.
// RQ8: Start read returns the previous result.
// RQ9: Busy low whole conversion, read release irrelevant.
// RQ10: ROM host waits for busy before rereading.
// RQ11: Blind host waits one conversion time.
// RQ12: Read within one clock after busy: no start.
// RQ13: Read during conversion returns previous result.
// RQ14: Host keeps start edge 20 ns off clock.
// RQ15: Host times starts from converter clock source.
// RQ16: Host polls or interrupts on busy rising.
// RQ17: Internal clock is input clock divided two.
// RQ18: 20 input cycles, 10 ticks, then stop.
// RQ19: SAR cleared on first internal tick.
// RQ20: Data driven only while selected and read.
module sar_adc_ctrl
   import sar_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Converter clock pin, sampled as a level
   input wire logic conv_clk_in,
   // Host read bus control
   input wire logic cs_n_in,
   input wire logic rd_n_in,
   // Digitised analog input, fraction of 2*Vref in 1/4096 steps
   input wire logic [`SAR_AIN_W-1:0] analog_input_in,
   // Status
   output logic busy_n_out,
   // Three-state data bus, bit 0 is result_bit0
   output logic [`SAR_CODE_W-1:0] data_out,
   output logic data_oe_out
);

   // ****************************************
   // Helpers
   // ****************************************

   // Comparator: keep the trial code if the rounded input reaches it
   function automatic logic sar_compare(input logic [`SAR_AIN_W-1:0] smp,
                                        input logic [`SAR_CODE_W-1:0] trial);
      logic [12:0] lhs;
      logic [12:0] rhs;
      lhs = {1'b0, smp} + `SAR_ROUND;
      rhs = {1'b0, trial, 4'h0};
      return lhs >= rhs;
   endfunction

   // Bit under trial for a given internal tick
   function automatic logic [`SAR_CODE_W-1:0] sar_mask(input logic [3:0] tick);
      logic [3:0] pos;
      pos = `SAR_INT_TICKS - tick;
      return 8'h01 << pos;
   endfunction

   // ****************************************
   // State
   // ****************************************

   sar_ctrl_t s_reg;
   sar_ctrl_t s_next;
   logic sel;
   logic start;
   logic fall;
   logic tick;
   logic finish;
   logic [3:0] tick_new;
   logic [`SAR_CODE_W-1:0] trial;
   logic [`SAR_CODE_W-1:0] decided;

   assign sel = ~cs_n_in & ~rd_n_in;
   // New start edge, ignored while running or just after completion
   assign start = sel & ~s_reg.sel_prev & (s_reg.state == SAR_IDLE) & ~s_reg.guard; // RQ1 RQ12

   sar_clkdiv u_clkdiv
   (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .conv_clk_in(conv_clk_in),
      .run_in(s_reg.state == SAR_CONV),
      .fall_out(fall),
      .tick_out(tick)
   );

   // ****************************************
   // Conversion sequencing
   // ****************************************

   always_comb
   begin
      s_next = s_reg;
      tick_new = s_reg.tick_cnt + 4'h1;
      trial = s_reg.sar | sar_mask(tick_new);
      decided = sar_compare(s_reg.sample, trial) ? trial : s_reg.sar; // RQ2 RQ3
      finish = 1'b0;
      s_next.sel_prev = sel;
      case (s_reg.state)
         SAR_IDLE:
         begin
            s_next.sample = analog_input_in; // RQ5
            if (fall)
            begin
               s_next.guard = 1'b0; // RQ12
            end
            if (start)
            begin
               s_next.state = SAR_CONV;
               s_next.busy_n = 1'b0; // RQ4
               s_next.fe_cnt = 5'h00;
               s_next.tick_cnt = 4'h0;
            end
         end
         SAR_CONV:
         begin
            if (s_reg.fe_cnt < `SAR_HOLD_EDGE)
            begin
               s_next.sample = analog_input_in; // RQ5
            end
            if (fall)
            begin
               s_next.fe_cnt = s_reg.fe_cnt + 5'h01;
            end
            if (tick)
            begin
               s_next.tick_cnt = tick_new;
               if (tick_new == 4'h1)
               begin
                  s_next.sar = '0; // RQ19
               end
               else if (tick_new >= `SAR_FIRST_BIT_TICK)
               begin
                  s_next.sar = decided;
               end
               if (tick_new == `SAR_INT_TICKS)
               begin
                  finish = 1'b1;
                  s_next.result = decided; // RQ6
                  s_next.busy_n = 1'b1; // RQ6 RQ9 RQ18
                  s_next.guard = 1'b1; // RQ12
                  s_next.state = SAR_IDLE;
               end
            end
         end
         default:
         begin
            s_next.state = SAR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         s_reg.state <= SAR_IDLE;
         s_reg.sel_prev <= 1'b0;
         s_reg.busy_n <= 1'b1;
         s_reg.guard <= 1'b0;
         s_reg.fe_cnt <= 5'h00;
         s_reg.tick_cnt <= 4'h0;
         s_reg.sar <= `SAR_RESULT_RST;
         s_reg.sample <= `SAR_SAMPLE_RST;
         s_reg.result <= `SAR_RESULT_RST;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************

   assign busy_n_out = s_reg.busy_n;
   // Latch always shows the last completed result
   assign data_out = s_reg.result; // RQ8 RQ13
   assign data_oe_out = sel; // RQ20

   // ****************************************
   // Checks
   // ****************************************

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   function automatic logic [`SAR_CODE_W-1:0] ref_code(input logic [`SAR_AIN_W-1:0] smp);
      logic [12:0] sum;
      sum = ({1'b0, smp} + `SAR_ROUND) >> `SAR_STEP_SH;
      return (sum > 13'h00ff) ? 8'hff : sum[7:0];
   endfunction

   sequence seq_start;
      start;
   endsequence

   sequence seq_busy_low;
      !busy_n_out [*2];
   endsequence

   a_start_busy_low: assert property (seq_start |=> seq_busy_low) // RQ4
      else $error("busy did not fall after start");

   a_busy_needs_sel: assert property ($fell(busy_n_out) |-> $past(sel)) // RQ1
      else $error("conversion began without select and read");

   a_hold_frozen: assert property ((s_reg.state == SAR_CONV && s_reg.fe_cnt >= `SAR_HOLD_EDGE) // RQ5
      |=> $stable(s_reg.sample))
      else $error("sample changed after hold edge");

   a_conv_length: assert property ($rose(busy_n_out) |-> s_reg.fe_cnt == `SAR_CONV_EDGES) // RQ18
      else $error("conversion length not 20 input cycles");

   a_sar_cleared: assert property ((tick && s_reg.tick_cnt == 4'h0) |=> s_reg.sar == 8'h00) // RQ19
      else $error("SAR not cleared on first tick");

   a_code_exact: assert property ($rose(busy_n_out) |-> data_out == ref_code(s_reg.sample)) // RQ3
      else $error("result code does not match rounded input");

   a_guard_blocks: assert property ((sel && !s_reg.sel_prev && s_reg.guard) |=> busy_n_out) // RQ12
      else $error("start accepted right after completion");

   a_old_data_held: assert property ((s_reg.state == SAR_CONV && !finish) |=> $stable(data_out)) // RQ13
      else $error("result changed during conversion");

   a_busy_in_conv: assert property ((s_reg.state == SAR_CONV) |-> !busy_n_out) // RQ9
      else $error("busy high while converting");

endmodule // sar_adc_ctrl

// >>> verification/sar_host_model.sv
`timescale 1ns/1ps
`include "sar_params.svh"

// ****
// Host read bus
// ****
module sar_host_model
   import sar_pkg::*;
(
   // Clock and status
   input wire logic clk_in,
   input wire logic busy_n_in,
   // Data bus
   input wire logic [`SAR_CODE_W-1:0] data_in,
   input wire logic data_oe_in,
   // Read control
   output logic cs_n_out,
   output logic rd_n_out
);
   initial
   begin
      cs_n_out = 1'b1;
      rd_n_out = 1'b1;
   end

   // Slow style holds until busy returns, ROM style holds four edges
   task automatic rd(input bit slow, output logic [`SAR_CODE_W-1:0] d, output int n, output bit hung);
      int k;
      n = 0;
      @(posedge clk_in);
      #1;
      cs_n_out = 1'b0;
      rd_n_out = 1'b0;
      // Busy and data are looked at mid-cycle, where they are settled
      for (k = 0; k < 300; k++)
      begin
         @(negedge clk_in);
         if (!busy_n_in)
            n++;
         if (slow ? (busy_n_in && n > 0) : (k == 3))
            break;
      end
      hung = (k == 300);
      d = data_oe_in ? data_in : 'x;
      // Release just after the rising edge following the falling edge that ends the wait
      @(posedge clk_in);
      #1;
      cs_n_out = 1'b1;
      rd_n_out = 1'b1;
   endtask
endmodule // sar_host_model

// >>> verification/test_sar_adc_read_start_interface.sv
`timescale 1ns/1ps
`include "sar_params.svh"

module test_sar_adc_read_start_interface;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic conv_clk_in = 1'b0;
   logic cs_n, rd_n, busy_n, oe;
   logic [`SAR_AIN_W-1:0] analog_input = 12'h000;
   logic [`SAR_CODE_W-1:0] dq, d;
   logic [11:0] tbl [5] = '{12'h000, 12'h007, 12'h008, 12'hfe7, 12'hfff};
   int bad_count = 0;
   int tests_run = 0;
   int n, i, k, prev, exp_code;
   bit hung;

   sar_adc_ctrl sar_adc_ctrl_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .conv_clk_in(conv_clk_in),
      .cs_n_in(cs_n), .rd_n_in(rd_n), .analog_input_in(analog_input), .busy_n_out(busy_n), .data_out(dq),
      .data_oe_out(oe));
   sar_host_model sar_host_model_inst (.clk_in(clk_in), .busy_n_in(busy_n), .data_in(dq),
      .data_oe_in(oe), .cs_n_out(cs_n), .rd_n_out(rd_n));

   initial
   begin
      forever #2 clk_in = ~clk_in;
   end
   initial
   begin
      #5;
      // 48 ns period leaves room to start more than 20 ns off a falling edge
      forever #24 conv_clk_in = ~conv_clk_in;
   end

   function automatic int code_of(int a);
      return ((a + 8) / 16 > 255) ? 255 : (a + 8) / 16;
   endfunction

   task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic tally_and_finish;
      if (bad_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic hang;
      bad_count++;
      $display("[ERR] busy_wait expected 1 seen 0");
      tally_and_finish();
   endtask

   task automatic hrd(input bit slow);
      sar_host_model_inst.rd(slow, d, n, hung);
      if (hung)
         hang();
   endtask

   initial
   begin
      void'($urandom(95));
      repeat (6) @(posedge clk_in);
      #1;
      rst_n_in = 1'b1;
      chk("busy_rst", 1, busy_n);
      chk("data_rst", `SAR_RESULT_RST, dq);
      prev = 0;
      for (i = 0; i < 12; i++)
      begin
         repeat (10) @(posedge clk_in);
         #1;
         analog_input = (i < 5) ? tbl[i] : 12'($urandom % 4096);
         exp_code = code_of(analog_input);
         chk("oe_idle", 0, oe);
         // Start reads are timed from the converter clock, 22 ns after its fall
         @(negedge conv_clk_in);
         repeat (5) @(posedge clk_in);
         if (i % 2 == 0)
         begin
            fork
               hrd(1'b1);
               begin
                  repeat (60) @(posedge clk_in);
                  #1;
                  analog_input = ~analog_input;
               end
            join
            chk("slow_data", exp_code, d);
            chk("busy_len", 1, n >= 229 && n <= 240);
         end
         else
         begin
            hrd(1'b0);
            chk("start_data", prev, d);
            chk("busy_low", 1, n > 0);
            hrd(1'b0);
            chk("mid_data", prev, d);
            chk("mid_busy", 4, n);
            for (k = 0; k < 300 && !busy_n; k++)
            begin
               @(posedge clk_in);
               #1;
            end
            if (k == 300)
               hang();
            hrd(1'b0);
            chk("guard_data", exp_code, d);
            chk("guard_busy", 0, n);
         end
         prev = exp_code;
      end
      tally_and_finish();
   end
endmodule // test_sar_adc_read_start_interface
